// File: dam_map.vh
// Register indices, field positions, reset values and class codes for the address modifier
`ifndef DAM_MAP_VH
`define DAM_MAP_VH

// Register indices; byte address on APB is four times the index
`define DAM_IDX_BANK 7'h79
`define DAM_IDX_IXH 7'h7a
`define DAM_IDX_IXM 7'h7b
`define DAM_IDX_IXL 7'h7c
`define DAM_IDX_STAT 7'h7f
`define DAM_IDX_LAST 7'h60
`define DAM_IDX_LIND 7'h61

// APB address field
`define DAM_PADDR_W 9
`define DAM_PADDR_IDX_HI 8
`define DAM_PADDR_IDX_LO 2
`define DAM_PADDR_ALIGN 2'h0

// Field positions
`define DAM_MPE_BIT 3
`define DAM_IXE_BIT 0
`define DAM_IXH_HI 2
`define DAM_IXH_LO 0

// Reset values
`define DAM_RST_NIB 4'h0
`define DAM_RST_ADDR 11'h000
`define DAM_RST_DATA 32'h0000_0000

// Index increment wrap point and result
`define DAM_IX_WRAP_FROM 11'h3ff
`define DAM_IX_WRAP_TO 11'h000
`define DAM_IX_ONE 11'h001

// Instruction classes presented by the core
`define DAM_CLS_EXEMPT 2'h0
`define DAM_CLS_MEM 2'h1
`define DAM_CLS_IND 2'h2
`define DAM_CLS_INC 2'h3

`endif

// File: dam_addr_mod.v
// Combinational data-memory address modification by index and row pointer
`timescale 1ns/1ps
`include "dam_map.vh"
module dam_addr_mod (
  input wire [1:0] cls,
  input wire [3:0] bank,
  input wire [2:0] row,
  input wire [3:0] col,
  input wire [10:0] index_value,
  input wire index_enable_flag,
  input wire [6:0] row_pointer,
  input wire row_pointer_enable,
  input wire [2:0] ind_row,
  input wire [3:0] ind_col,
  output reg [10:0] mem_addr,
  output reg [10:0] ind_addr,
  output reg ix_applied,
  output reg mp_applied
);
  wire [10:0] raw_addr;
  wire [10:0] raw_ind;

  assign raw_addr = {bank, row, col};
  assign raw_ind = {bank, ind_row, ind_col};

  always @* begin
    mem_addr = raw_addr;
    ind_addr = raw_ind;
    ix_applied = 1'b0;
    mp_applied = 1'b0;
    case (cls)
      `DAM_CLS_MEM, `DAM_CLS_IND: begin
        if (index_enable_flag) begin
          mem_addr = raw_addr | index_value;
          ix_applied = 1'b1;
        end
        if (cls == `DAM_CLS_IND && row_pointer_enable) begin
          ind_addr = {row_pointer, ind_col};
          mp_applied = 1'b1;
        end
      end
      default: begin
        mem_addr = raw_addr;
        ind_addr = raw_ind;
      end
    endcase
  end
endmodule // dam_addr_mod

// File: dam_top.v
// Bank select, index register and row pointer with APB access and address modification
`timescale 1ns/1ps
`include "dam_map.vh"

// Operation
// - Four-bit bank register picks data-memory bank 0 through 15.
// - Bank register writes succeed whatever bank is currently selected.
// - Index is 11 bits: low three bits of 7AH, then 7BH, 7CH.
// - Index enable flag is bit 0 of the status nibble at 7FH.
// - Row pointer is 7 bits sharing index upper bits in 7AH and 7BH.
// - Row pointer enable flag lives in the nibble at 7AH.
// - With index enabled, data-memory instructions use bank/row/column ORed with index.
// - Exempt instruction classes never get index modification.
// - With pointer enabled, indirect transfers take bank and row from the pointer.
// - Row pointer modifies no instruction except general-register indirect transfers.
// - Index increment adds one, wrapping 3FFH to 000H.
module dam_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [8:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire wdt_reset_req,
  input wire ce_reset_req,
  input wire core_valid,
  input wire [1:0] core_cls,
  input wire [2:0] core_row,
  input wire [3:0] core_col,
  input wire [2:0] core_ind_row,
  input wire [3:0] core_ind_col,
  output wire [3:0] bank_sel,
  output wire [10:0] real_addr,
  output wire [10:0] real_ind_addr,
  output wire addr_valid,
  output wire ix_applied,
  output wire mp_applied
);
  // System register nibbles
  reg [3:0] bank_ff;
  reg [3:0] ixh_ff;
  reg [3:0] ixm_ff;
  reg [3:0] ixl_ff;
  reg [3:0] stat_ff;
  reg [3:0] nxt_bank;
  reg [3:0] nxt_ixh;
  reg [3:0] nxt_ixm;
  reg [3:0] nxt_ixl;
  reg [3:0] nxt_stat;

  // Bus answer registers
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] nxt_prdata;
  reg nxt_pready;
  reg nxt_pslverr;

  // Registered address results
  reg [10:0] real_addr_ff;
  reg [10:0] real_ind_ff;
  reg addr_valid_ff;
  reg ix_applied_ff;
  reg mp_applied_ff;

  // Decoded views of the nibbles
  wire [10:0] index_value;
  wire [6:0] row_pointer;
  wire index_enable_flag;
  wire row_pointer_enable;
  wire [10:0] index_next;

  // Bus decode
  wire [6:0] reg_idx;
  wire aligned;
  wire setup_phase;
  wire wr_commit;
  wire soft_clear;
  reg mapped;
  reg [3:0] rd_nib;
  reg [10:0] rd_wide;
  reg wide_sel;

  // Modifier outputs
  wire [10:0] mod_mem_addr;
  wire [10:0] mod_ind_addr;
  wire mod_ix_applied;
  wire mod_mp_applied;
  wire inc_req;

  assign index_value = {ixh_ff[`DAM_IXH_HI:`DAM_IXH_LO], ixm_ff, ixl_ff};
  assign row_pointer = {ixh_ff[`DAM_IXH_HI:`DAM_IXH_LO], ixm_ff};
  assign row_pointer_enable = ixh_ff[`DAM_MPE_BIT];
  assign index_enable_flag = stat_ff[`DAM_IXE_BIT];

  // Increment with the documented wrap point
  assign index_next = (index_value == `DAM_IX_WRAP_FROM) ? `DAM_IX_WRAP_TO : index_value + `DAM_IX_ONE;

  assign reg_idx = paddr[`DAM_PADDR_IDX_HI:`DAM_PADDR_IDX_LO];
  assign aligned = (paddr[1:0] == `DAM_PADDR_ALIGN);
  assign setup_phase = psel & ~penable;
  assign wr_commit = psel & penable & pready_ff & pwrite & mapped & aligned;
  assign soft_clear = wdt_reset_req | ce_reset_req;
  assign inc_req = core_valid & (core_cls == `DAM_CLS_INC);

  // Address decode and read mux
  always @* begin
    mapped = 1'b1;
    rd_nib = `DAM_RST_NIB;
    rd_wide = `DAM_RST_ADDR;
    wide_sel = 1'b0;
    case (reg_idx)
      `DAM_IDX_BANK: rd_nib = bank_ff;
      `DAM_IDX_IXH: rd_nib = ixh_ff;
      `DAM_IDX_IXM: rd_nib = ixm_ff;
      `DAM_IDX_IXL: rd_nib = ixl_ff;
      `DAM_IDX_STAT: rd_nib = stat_ff;
      `DAM_IDX_LAST: begin
        rd_wide = real_addr_ff;
        wide_sel = 1'b1;
      end
      `DAM_IDX_LIND: begin
        rd_wide = real_ind_ff;
        wide_sel = 1'b1;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Answer prepared in setup, presented for exactly one access cycle
  always @* begin
    nxt_pready = setup_phase;
    nxt_pslverr = setup_phase & ~(mapped & aligned);
    nxt_prdata = prdata_ff;
    if (setup_phase) begin
      if (!pwrite && mapped && aligned) begin
        if (wide_sel) begin
          nxt_prdata = {21'h000000, rd_wide};
        end else begin
          nxt_prdata = {28'h0000000, rd_nib};
        end
      end else begin
        nxt_prdata = `DAM_RST_DATA;
      end
    end
  end

  // Register next values; bus write wins over increment in the same cycle
  always @* begin
    nxt_bank = bank_ff;
    nxt_ixh = ixh_ff;
    nxt_ixm = ixm_ff;
    nxt_ixl = ixl_ff;
    nxt_stat = stat_ff;
    if (inc_req) begin
      nxt_ixh = {ixh_ff[`DAM_MPE_BIT], index_next[10:8]};
      nxt_ixm = index_next[7:4];
      nxt_ixl = index_next[3:0];
    end
    if (wr_commit) begin
      case (reg_idx)
        `DAM_IDX_BANK: nxt_bank = pwdata[3:0];
        `DAM_IDX_IXH: nxt_ixh = pwdata[3:0];
        `DAM_IDX_IXM: nxt_ixm = pwdata[3:0];
        `DAM_IDX_IXL: nxt_ixl = pwdata[3:0];
        `DAM_IDX_STAT: nxt_stat = pwdata[3:0];
        default: nxt_bank = bank_ff;
      endcase
    end
    if (soft_clear) begin
      nxt_bank = `DAM_RST_NIB;
      nxt_ixh = `DAM_RST_NIB;
      nxt_ixm = `DAM_RST_NIB;
      nxt_ixl = `DAM_RST_NIB;
      nxt_stat = `DAM_RST_NIB;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_ff <= `DAM_RST_NIB;
      ixh_ff <= `DAM_RST_NIB;
      ixm_ff <= `DAM_RST_NIB;
      ixl_ff <= `DAM_RST_NIB;
      stat_ff <= `DAM_RST_NIB;
    end else begin
      bank_ff <= nxt_bank;
      ixh_ff <= nxt_ixh;
      ixm_ff <= nxt_ixm;
      ixl_ff <= nxt_ixl;
      stat_ff <= nxt_stat;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= `DAM_RST_DATA;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Bank comes from the bank register, row and column from the instruction
  dam_addr_mod u_mod (
    .cls(core_cls),
    .bank(bank_ff),
    .row(core_row),
    .col(core_col),
    .index_value(index_value),
    .index_enable_flag(index_enable_flag),
    .row_pointer(row_pointer),
    .row_pointer_enable(row_pointer_enable),
    .ind_row(core_ind_row),
    .ind_col(core_ind_col),
    .mem_addr(mod_mem_addr),
    .ind_addr(mod_ind_addr),
    .ix_applied(mod_ix_applied),
    .mp_applied(mod_mp_applied)
  );

  // Results registered one cycle after the core request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      real_addr_ff <= `DAM_RST_ADDR;
      real_ind_ff <= `DAM_RST_ADDR;
      addr_valid_ff <= 1'b0;
      ix_applied_ff <= 1'b0;
      mp_applied_ff <= 1'b0;
    end else begin
      addr_valid_ff <= core_valid;
      if (core_valid) begin
        real_addr_ff <= mod_mem_addr;
        real_ind_ff <= mod_ind_addr;
        ix_applied_ff <= mod_ix_applied;
        mp_applied_ff <= mod_mp_applied;
      end else begin
        ix_applied_ff <= 1'b0;
        mp_applied_ff <= 1'b0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign bank_sel = bank_ff;
  assign real_addr = real_addr_ff;
  assign real_ind_addr = real_ind_ff;
  assign addr_valid = addr_valid_ff;
  assign ix_applied = ix_applied_ff;
  assign mp_applied = mp_applied_ff;
endmodule // dam_top

// File: dam_top_monitor.sv
// Concurrent checks on the address modifier ports
`timescale 1ns/1ps
module dam_top_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [8:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire wdt_reset_req,
  input wire ce_reset_req,
  input wire core_valid,
  input wire [1:0] core_cls,
  input wire [2:0] core_row,
  input wire [3:0] core_col,
  input wire [3:0] core_ind_col,
  input wire [3:0] bank_sel,
  input wire [10:0] real_addr,
  input wire [10:0] real_ind_addr,
  input wire addr_valid,
  input wire ix_applied,
  input wire mp_applied
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] base_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) base_ff <= 11'h000;
    else base_ff <= {bank_sel, core_row, core_col};
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bank_wr;
    psel && penable && pready && pwrite && paddr == 9'h1e4 && !wdt_reset_req && !ce_reset_req;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
  a_ix_mem_only: assert property (ix_applied |-> addr_valid && $past(core_cls) inside {2'h1, 2'h2})
    else $error("index on wrong class");
  a_mp_ind_only: assert property (mp_applied |-> $past(core_cls) == 2'h2) else $error("pointer on wrong class");
  a_mp_keeps_col: assert property (mp_applied |-> real_ind_addr[3:0] == $past(core_ind_col))
    else $error("pointer column wrong");
  a_exempt_plain: assert property (core_valid && core_cls inside {2'h0, 2'h3} |=> real_addr == base_ff)
    else $error("exempt address modified");
  a_mem_or_base: assert property (core_valid && core_cls == 2'h1 |=> (real_addr | base_ff) == real_addr)
    else $error("address lost base bits");
  a_bank_write: assert property (s_bank_wr |=> {28'h0, bank_sel} == ($past(pwdata) & 32'hf))
    else $error("bank write lost");
  a_sys_clear: assert property (wdt_reset_req || ce_reset_req |=> bank_sel == 4'h0) else $error("bank not cleared");
endmodule // dam_top_monitor

bind dam_top dam_top_monitor u_dam_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .wdt_reset_req(wdt_reset_req),
  .ce_reset_req(ce_reset_req), .core_valid(core_valid), .core_cls(core_cls), .core_row(core_row),
  .core_col(core_col), .core_ind_col(core_ind_col), .bank_sel(bank_sel), .real_addr(real_addr),
  .real_ind_addr(real_ind_addr), .addr_valid(addr_valid), .ix_applied(ix_applied), .mp_applied(mp_applied));

// File: dam_top_test.sv
// Self-checking bench for the address modifier
`timescale 1ns/1ps
module dam_top_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wdt = 0, ce = 0, cv = 0, er, prdy, perr, av, ixa, mpa;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] cls = 2'h0;
  logic [2:0] row = 3'h0, irow = 3'h0;
  logic [3:0] col = 4'h0, icol = 4'h0, bsel;
  logic [10:0] ra, ria, ix, ea, eia;
  logic [3:0] m [5];
  logic [8:0] adr [5] = '{9'h1e4, 9'h1e8, 9'h1ec, 9'h1f0, 9'h1fc};
  int fails = 0, checks_done = 0;
  dam_top u_dam_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(prdy), .pslverr(perr), .wdt_reset_req(wdt), .ce_reset_req(ce),
    .core_valid(cv), .core_cls(cls), .core_row(row), .core_col(col), .core_ind_row(irow), .core_ind_col(icol),
    .bank_sel(bsel), .real_addr(ra), .real_ind_addr(ria), .addr_valid(av), .ix_applied(ixa), .mp_applied(mpa));
  initial forever #10 pclk = ~pclk;
  task print_verdict;
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    rd = prdata;
    er = perr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
    if (n >= 16) begin
      fails++;
      print_verdict;
    end
  endtask
  task rdall;
    for (int i = 0; i < 5; i++) begin
      apb(0, adr[i], 32'h0);
      chk("prdata", {28'h0, m[i]}, rd);
      chk("pslverr", 32'h0, 32'(er));
    end
  endtask
  task setregs;
    for (int i = 0; i < 5; i++) apb(1, adr[i], {28'($urandom), m[i]});
    ix = {m[1][2:0], m[2], m[3]};
    chk("bank_sel", 32'(m[0]), 32'(bsel));
  endtask
  task core(input logic [1:0] c, input logic [2:0] r, input logic [3:0] k, input logic [2:0] ir, input logic [3:0] ik);
    logic on;
    on = m[4][0] && c inside {2'h1, 2'h2};
    cv <= 1; cls <= c; row <= r; col <= k; irow <= ir; icol <= ik;
    @(posedge pclk);
    cv <= 0;
    #1;
    ea = on ? ({m[0], r, k} | ix) : {m[0], r, k};
    chk("real_addr", 32'(ea), 32'(ra));
    chk("ix_applied", 32'(on), 32'(ixa));
    chk("mp_applied", 32'(m[1][3] && c == 2'h2), 32'(mpa));
    chk("addr_valid", 32'h1, 32'(av));
    eia = (m[1][3] && c == 2'h2) ? {ix[10:4], ik} : {m[0], ir, ik};
    chk("real_ind_addr", 32'(eia), 32'(ria));
    if (c == 2'h3) begin
      ix = (ix == 11'h3ff) ? 11'h000 : ix + 11'h001;
      m[1][2:0] = ix[10:8];
      m[2] = ix[7:4];
      m[3] = ix[3:0];
    end
    @(posedge pclk);
  endtask
  initial begin
    void'($urandom(93));
    foreach (m[i]) m[i] = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rdall;
    apb(0, 9'h100, 32'h0);
    chk("unmapped pslverr", 32'h1, 32'(er));
    for (int t = 0; t < 40; t++) begin
      foreach (m[i]) m[i] = 4'($urandom);
      // Full bank set: this build has banks 10 to 15, small-variant software skips them
      if (t < 16) m[0] = 4'(t);
      if (t == 16) m = '{4'h5, 4'hb, 4'hf, 4'hf, 4'h1};
      setregs;
      if (t == 17) apb(1, 9'h1e5, 32'h7);
      if (t == 17) chk("misaligned pslverr", 32'h1, 32'(er));
      core(t == 16 ? 2'h3 : 2'($urandom), 3'($urandom), 4'($urandom), 3'($urandom), 4'($urandom));
      rdall;
      apb(0, 9'h180, 32'h0);
      chk("last real_addr", 32'(ea), rd);
      apb(0, 9'h184, 32'h0);
      chk("last real_ind_addr", 32'(eia), rd);
    end
    for (int k = 0; k < 2; k++) begin
      wdt <= (k == 0);
      ce <= (k == 1);
      @(posedge pclk);
      wdt <= 0;
      ce <= 0;
      @(posedge pclk);
      foreach (m[i]) m[i] = 4'h0;
      rdall;
      foreach (m[i]) m[i] = 4'($urandom);
      setregs;
    end
    // Second power-on style reset in mid-run
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    foreach (m[i]) m[i] = 4'h0;
    chk("real_addr after reset", 32'h0, 32'(ra));
    chk("bank_sel after reset", 32'h0, 32'(bsel));
    rdall;
    print_verdict;
  end
endmodule // dam_top_test
